// file: design/sadc_pkg.sv
// Shared constants, field layouts and types of the sensor converter control
package sadc_pkg;

	// ********************************************************************
	// Register addresses
	// ********************************************************************
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_CONTROL = 16'h22ab;
	localparam logic [15:0] ADDR_RESULT_HIGH = 16'h22ac;
	localparam logic [15:0] ADDR_RESULT_LOW = 16'h22ad;
	localparam logic [15:0] ADDR_BIAS_HIGH = 16'h22ae;
	localparam logic [15:0] ADDR_BIAS_LOW = 16'h22af;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'h22b0;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'h22b1;

	// ********************************************************************
	// Field layouts and reset values
	// ********************************************************************
	localparam int DATA_W = 8;
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_DONE_BIT = 6;
	localparam int REF_MSB = 5;
	localparam int REF_LSB = 4;
	localparam int CHAN_MSB = 3;
	localparam int VAL_W = 15;
	localparam int MEAN_W = 8;
	localparam int HIGH_LSB = 7;
	localparam int LOW_MSB = 6;
	localparam int LOW_SHIFT = 1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [14:0] RESET_VAL = 15'h0000;
	localparam logic [6:0] PAD_ZERO = 7'h00;
	localparam logic RSVD_BIT_VAL = 1'b0;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_RSVD_BIT = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ********************************************************************
	// Reference and input channel codes
	// ********************************************************************
	localparam logic [1:0] REF_INTERNAL = 2'h0;
	localparam logic [1:0] REF_RESERVED = 2'h1;
	localparam logic [1:0] REF_EXTERNAL = 2'h2;
	localparam logic [1:0] REF_SUPPLY = 2'h3;
	localparam logic [3:0] CH_LAST_VALID = 4'h9;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int SAMPLE_HZ = 8000;
	localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
	localparam int CNT_W = 16;
	localparam int SYNC_STAGES = 3;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} sadc_bus_req_type;

	typedef struct packed {
		logic enable;
		logic [1:0] ref_sel;
		logic [3:0] chan;
	} sadc_ctrl_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_COUNT = 3'b010,
		ST_CAPTURE = 3'b100
	} sadc_state_type;

	// Raw sample minus bias, floored at zero
	function automatic logic [14:0] sadc_sat_sub(input logic [14:0] a,
		input logic [14:0] b);
		return (a > b) ? (a - b) : RESET_VAL;
	endfunction : sadc_sat_sub

endpackage : sadc_pkg

// file: design/sadc_pin_sync.sv
// Three-stage synchroniser for a bus arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sadc_pin_sync
	import sadc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output var logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	// Accept a new value only once stages two and three agree
	always_comb begin
		q_next = q_reg;
		if (s2_reg == s3_reg) begin
			q_next = s3_reg;
		end
	end

	// Register chain; stage one feeds stage two only
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg <= '0;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= q_next;
		end
	end

	assign q_out = q_reg;

endmodule : sadc_pin_sync
`default_nettype wire

// file: design/sadc_control.sv
// Sensor converter control: registers, fixed-rate sampling, bias correction
//
// Notes on behaviour
// - Each result carries eight meaningful bits taken from the selected input.
// - Samples are taken at one fixed 8 kHz rate; no setting changes it.
// - Control bits 5:4 pick the reference; code 01 is reserved.
// - Control bits 3:0 pick the input channel; codes above 1001 reserved.
// - Result is 15 bits: high register bits 14:7, low register 7:1, bit 0 zero.
// - Only the upper eight result bits are meaningful data.
// - A software-written bias corrects the offset before the result is shown.
// - Bias is 15 bits split like the result; both halves read and write.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sadc_control
	import sadc_pkg::*;
#(
	parameter int SAMPLE_PERIOD_CYCLES = SAMPLE_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire sadc_bus_req_type bus_in,
	input wire logic [7:0] raw_sample_in,
	output var logic [7:0] rdata_out,
	output var logic irq_out,
	output var logic converter_enable_out,
	output var logic [1:0] reference_select_out,
	output var logic [3:0] input_channel_select_out,
	output var logic sample_strobe_out
);

	// ********************************************************************
	// Declarations
	// ********************************************************************
	localparam logic [15:0] LAST_COUNT = 16'(SAMPLE_PERIOD_CYCLES - 2);

	sadc_ctrl_type ctrl_reg;
	sadc_ctrl_type ctrl_next;
	logic done_reg;
	logic done_next;
	logic [14:0] bias_reg;
	logic [14:0] bias_next;
	logic [14:0] result_reg;
	logic [14:0] result_next;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] mask_reg;
	logic [1:0] mask_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic irq_reg;
	logic irq_next;
	sadc_state_type state_reg;
	sadc_state_type state_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic strobe_reg;
	logic strobe_next;
	logic result_load;
	logic cfg_reserved;
	logic [7:0] sample_sync;
	logic [7:0] read_mux;
	logic [14:0] raw_full;

	// ********************************************************************
	// Sample input crossing
	// ********************************************************************
	sadc_pin_sync #(
		.WIDTH(MEAN_W)
	) u_sample_sync (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.d_in(raw_sample_in),
		.q_out(sample_sync)
	);

	// Eight meaningful bits sit at the top, lower bits padded zero
	assign raw_full = {sample_sync, PAD_ZERO};

	// ********************************************************************
	// Conversion sequencer
	// ********************************************************************

	// Fixed period counter; no register reaches the period
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		strobe_next = 1'b0;
		result_next = result_reg;
		result_load = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				count_next = '0;
				if (ctrl_reg.enable) begin
					state_next = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (!ctrl_reg.enable) begin
					state_next = ST_IDLE;
					count_next = '0;
				end else if (count_reg == LAST_COUNT) begin
					state_next = ST_CAPTURE;
					count_next = '0;
				end else begin
					count_next = count_reg + 16'h0001;
				end
			end
			ST_CAPTURE: begin
				// Bias-corrected value stored once per period
				result_next = sadc_sat_sub(raw_full, bias_reg);
				result_load = 1'b1;
				strobe_next = 1'b1;
				state_next = ctrl_reg.enable ? ST_COUNT : ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
				count_next = '0;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_IDLE;
			count_reg <= '0;
			strobe_reg <= 1'b0;
			result_reg <= RESET_VAL;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			strobe_reg <= strobe_next;
			result_reg <= result_next;
		end
	end

	// ********************************************************************
	// Register file
	// ********************************************************************

	// Reserved reference or channel code written while configuring
	assign cfg_reserved = bus_in.wr && (bus_in.addr == ADDR_CONTROL) &&
		((bus_in.wdata[REF_MSB:REF_LSB] == REF_RESERVED) ||
		(bus_in.wdata[CHAN_MSB:0] > CH_LAST_VALID));

	// Read data selection; unmapped addresses read zero
	always_comb begin
		case (bus_in.addr)
			ADDR_CONTROL: read_mux = {ctrl_reg.enable, done_reg,
				ctrl_reg.ref_sel, ctrl_reg.chan};
			ADDR_RESULT_HIGH: read_mux = result_reg[VAL_W-1:HIGH_LSB];
			ADDR_RESULT_LOW: read_mux = {result_reg[LOW_MSB:0],
				RSVD_BIT_VAL};
			ADDR_BIAS_HIGH: read_mux = bias_reg[VAL_W-1:HIGH_LSB];
			ADDR_BIAS_LOW: read_mux = {bias_reg[LOW_MSB:0], RSVD_BIT_VAL};
			ADDR_IRQ_STATUS: read_mux = {6'h00, status_reg};
			ADDR_IRQ_MASK: read_mux = {6'h00, mask_reg};
			default: read_mux = RESET_BYTE;
		endcase
	end

	// Writes, read side effects, event flags; hardware set beats clear
	always_comb begin
		ctrl_next = ctrl_reg;
		done_next = done_reg;
		bias_next = bias_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		rdata_next = RESET_BYTE;
		if (bus_in.wr) begin
			case (bus_in.addr)
				ADDR_CONTROL: begin
					ctrl_next.enable = bus_in.wdata[CTRL_EN_BIT];
					ctrl_next.ref_sel = bus_in.wdata[REF_MSB:REF_LSB];
					ctrl_next.chan = bus_in.wdata[CHAN_MSB:0];
				end
				ADDR_BIAS_HIGH: begin
					bias_next[VAL_W-1:HIGH_LSB] = bus_in.wdata;
				end
				ADDR_BIAS_LOW: begin
					bias_next[LOW_MSB:0] = bus_in.wdata[DATA_W-1:LOW_SHIFT];
				end
				ADDR_IRQ_MASK: begin
					mask_next = bus_in.wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (bus_in.rd) begin
			rdata_next = read_mux;
			if (bus_in.addr == ADDR_CONTROL) begin
				done_next = 1'b0;
			end
			if (bus_in.addr == ADDR_IRQ_STATUS) begin
				status_next = IRQ_RESET;
			end
		end
		if (result_load) begin
			done_next = 1'b1;
			status_next[IRQ_DONE_BIT] = 1'b1;
		end
		if (cfg_reserved) begin
			status_next[IRQ_RSVD_BIT] = 1'b1;
		end
		irq_next = |(status_next & mask_next);
	end

	// Register file flops
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= '0;
			done_reg <= 1'b0;
			bias_reg <= RESET_VAL;
			mask_reg <= IRQ_RESET;
			status_reg <= IRQ_RESET;
			rdata_reg <= RESET_BYTE;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			done_reg <= done_next;
			bias_reg <= bias_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end

	// Outputs straight from flops
	assign rdata_out = rdata_reg;
	assign irq_out = irq_reg;
	assign converter_enable_out = ctrl_reg.enable;
	assign reference_select_out = ctrl_reg.ref_sel;
	assign input_channel_select_out = ctrl_reg.chan;
	assign sample_strobe_out = strobe_reg;

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	localparam logic [15:0] GAP_LAST = 16'(SAMPLE_PERIOD_CYCLES - 1);
	logic [15:0] gap_reg;
	logic [15:0] gap_next;
	logic seen_reg;
	logic seen_next;

	// Cycles since last strobe while continuously enabled
	always_comb begin
		gap_next = strobe_reg ? 16'h0000 : gap_reg + 16'h0001;
		seen_next = (seen_reg || strobe_reg) && ctrl_reg.enable;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap_reg <= '0;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= gap_next;
			seen_reg <= seen_next;
		end
	end

	sample_period_a: assert property (
		strobe_reg && seen_reg |-> gap_reg == GAP_LAST)
		else $error("sample spacing differs from fixed period");

	done_flag_a: assert property (
		state_reg == ST_CAPTURE |=> done_reg && strobe_reg)
		else $error("done flag not set after new result");

	bias_sub_a: assert property (
		strobe_reg |-> result_reg == sadc_sat_sub(
		{$past(sample_sync), PAD_ZERO}, $past(bias_reg)))
		else $error("result is not sample minus bias floored");

	result_high_a: assert property (
		bus_in.rd && bus_in.addr == ADDR_RESULT_HIGH && !result_load
		|=> rdata_out == $past(result_reg[VAL_W-1:HIGH_LSB]))
		else $error("high result read mismatch");

	result_low_a: assert property (
		bus_in.rd && bus_in.addr == ADDR_RESULT_LOW && !result_load
		|=> rdata_out == {$past(result_reg[LOW_MSB:0]), RSVD_BIT_VAL})
		else $error("low result read mismatch");

	bias_high_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_BIAS_HIGH
		|=> bias_reg[VAL_W-1:HIGH_LSB] == $past(bus_in.wdata))
		else $error("bias high write lost");

	bias_low_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_BIAS_LOW
		|=> bias_reg[LOW_MSB:0] == $past(bus_in.wdata[DATA_W-1:LOW_SHIFT]))
		else $error("bias low write lost");

	select_out_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_CONTROL
		|=> reference_select_out == $past(bus_in.wdata[REF_MSB:REF_LSB])
		&& input_channel_select_out == $past(bus_in.wdata[CHAN_MSB:0]))
		else $error("selection outputs not updated");

	disabled_quiet_a: assert property (
		!converter_enable_out [*3] |-> !sample_strobe_out)
		else $error("sampling while disabled");

	eight_bit_a: assert property (
		strobe_reg && $past(bias_reg) == RESET_VAL
		|-> result_reg[LOW_MSB:0] == PAD_ZERO)
		else $error("raw result has more than eight bits");

	irq_done_a: assert property (
		strobe_reg && mask_reg[IRQ_DONE_BIT] |-> irq_out)
		else $error("unmasked done did not raise interrupt");

endmodule : sadc_control
`default_nettype wire

// file: tb/test_sensor_adc_control.sv
// Self-checking bench of the sensor converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); \
	end \
end
module test_sensor_adc_control
	import sadc_pkg::*;
;
	// ********************************************************************
	// Signals and design under test
	// ********************************************************************
	localparam int PERIOD = 20;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	sadc_bus_req_type bus_req;
	logic [7:0] raw_sample;
	logic [7:0] rdata;
	logic irq;
	logic en_o;
	logic [1:0] ref_o;
	logic [3:0] chan_o;
	logic strobe;
	int fails = 0;
	int num_checks = 0;
	int n;
	int r;
	int bias_m;

	sadc_control #(.SAMPLE_PERIOD_CYCLES(PERIOD)) dut (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.bus_in(bus_req),
		.raw_sample_in(raw_sample),
		.rdata_out(rdata),
		.irq_out(irq),
		.converter_enable_out(en_o),
		.reference_select_out(ref_o),
		.input_channel_select_out(chan_o),
		.sample_strobe_out(strobe)
	);

	// Free-running 100 MHz clock
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// ********************************************************************
	// Bus tasks and reference model
	// ********************************************************************
	// One-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk_in);
		bus_req <= '{default: '0};
	endtask : wr

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk_in);
		bus_req <= '{default: '0};
		#1;
		d = rdata;
	endtask : rd

	// Read and compare against an expected byte
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		`CHK(v, e, "register read")
	endtask : chk_rd

	// Count cycles until the next result strobe, bounded
	task automatic wait_strobe(output int cnt);
		cnt = 0;
		for (int i = 0; i < 200; i++) begin
			@(posedge ref_clk_in);
			#1;
			cnt++;
			if (strobe === 1'b1) return;
		end
		fails++;
		$display("unexpected at %0t: no result strobe", $time);
		finish_test();
	endtask : wait_strobe

	// Corrected value: sample at the top eight bits minus bias, floored
	function automatic int exp_res(input int s, input int b);
		int v;
		v = s * 128 - b;
		return (v < 0) ? 0 : v;
	endfunction : exp_res

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		bus_req = '{default: '0};
		raw_sample = 8'h00;
		void'($urandom(72513));
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;

		// Reset values, read-only and unmapped places
		chk_rd(ADDR_CONTROL, 8'h00);
		chk_rd(ADDR_RESULT_HIGH, 8'h00);
		chk_rd(ADDR_RESULT_LOW, 8'h00);
		chk_rd(ADDR_BIAS_HIGH, 8'h00);
		chk_rd(ADDR_BIAS_LOW, 8'h00);
		chk_rd(ADDR_IRQ_STATUS, 8'h00);
		chk_rd(ADDR_IRQ_MASK, 8'h00);
		wr(ADDR_RESULT_HIGH, 8'hff);
		wr(ADDR_RESULT_LOW, 8'hff);
		wr(16'h22b2, 8'h5a);
		chk_rd(ADDR_RESULT_HIGH, 8'h00);
		chk_rd(ADDR_RESULT_LOW, 8'h00);
		chk_rd(16'h22b2, 8'h00);
		$display("test reset_map done");

		// Every reference and channel code, reserved ones flagged
		wr(ADDR_IRQ_MASK, 8'h02);
		for (int rf = 0; rf < 4; rf++) begin
			for (int c = 0; c < 16; c++) begin
				wr(ADDR_CONTROL, {2'b01, 2'(rf), 4'(c)});
				#1;
				`CHK(ref_o, 2'(rf), "reference")
				`CHK(chan_o, 4'(c), "channel")
				`CHK(en_o, 1'b0, "enable")
				`CHK(irq, (rf == 1 || c > 9), "reserved irq")
				chk_rd(ADDR_CONTROL, {2'b00, 2'(rf), 4'(c)});
				chk_rd(ADDR_IRQ_STATUS, {6'h00, (rf == 1 || c > 9), 1'b0});
			end
		end
		$display("test codes done");

		// Conversions: random bias, saturating bias, zero bias
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk_in);
			raw_sample <= 8'($urandom());
			bias_m = (k == 0) ? int'($urandom() & 32'h3fff) : 0;
			if (k == 1) bias_m = 32'h7fff;
			wr(ADDR_BIAS_HIGH, 8'(bias_m >> 7));
			wr(ADDR_BIAS_LOW, 8'((bias_m & 127) << 1));
			chk_rd(ADDR_BIAS_HIGH, 8'(bias_m >> 7));
			chk_rd(ADDR_BIAS_LOW, 8'((bias_m & 127) << 1));
			wr(ADDR_IRQ_MASK, (k == 1) ? 8'h00 : 8'h01);
			wr(ADDR_CONTROL, 8'h80 | 8'(k));
			#1;
			`CHK(en_o, 1'b1, "enable out")
			wait_strobe(n);
			`CHK(n, PERIOD + 1, "first strobe latency")
			wait_strobe(n);
			`CHK(n, PERIOD, "sample period")
			`CHK(irq, (k != 1), "done irq")
			r = exp_res(int'(raw_sample), bias_m);
			chk_rd(ADDR_RESULT_HIGH, 8'(r >> 7));
			chk_rd(ADDR_RESULT_LOW, 8'((r & 127) << 1));
			chk_rd(ADDR_IRQ_STATUS, 8'h01);
			`CHK(irq, 1'b0, "irq after status read")
			chk_rd(ADDR_CONTROL, 8'hc0 | 8'(k));
			chk_rd(ADDR_CONTROL, 8'h80 | 8'(k));
			wr(ADDR_CONTROL, 8'h00);
			repeat (3) @(posedge ref_clk_in);
			$display("test conversion %0d done", k);
		end

		// Reset in mid-run clears configuration and results
		wr(ADDR_BIAS_HIGH, 8'h5a);
		wr(ADDR_CONTROL, 8'h80);
		repeat (PERIOD + 4) @(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		#1;
		`CHK(en_o, 1'b0, "enable after reset")
		`CHK(irq, 1'b0, "irq after reset")
		chk_rd(ADDR_BIAS_HIGH, 8'h00);
		chk_rd(ADDR_RESULT_HIGH, 8'h00);
		chk_rd(ADDR_CONTROL, 8'h00);
		$display("test mid reset done");

		// Disabled converter stays silent
		n = 0;
		for (int i = 0; i < 3 * PERIOD; i++) begin
			@(posedge ref_clk_in);
			#1;
			if (strobe === 1'b1) n++;
		end
		`CHK(n, 0, "strobe while disabled")
		$display("test disable done");
		finish_test();
	end

endmodule : test_sensor_adc_control
`undef CHK
`default_nettype wire
